// ### rtl/tap_cfg_port.sv
// Purpose: boundary-scan data registers and configuration sequencing
// Assumes: tap clock far slower than core_clk_in; fabric side on core clock
// Notes:   tap pins are oversampled; startup length is a parameter

// What this block does
// - bypass is one bit, cleared on capture
// - fixed 32-bit identification shifted under IDCODE
// - identification value ends in a one
// - 16-bit register feeds configuration words
// - usercode reads 32'h0fffffff until configured
// - fabric chains reachable only after configuration
// - fabric sees shared data, reset, shift, update
// - reload accepted only after program or shutdown
// - configuration data enters most significant first
// - startup instruction begins startup sequence
// - startup clock chosen among three sources
// - tap-clocked startup advances only in idle
// - shutdown runs under entry instruction
// - shutdown walks startup phases in reverse
// - six-bit instruction register selects data registers
// - entry opcode causes full shutdown
// - exit opcode causes startup
module tap_cfg_port #(
  parameter logic [31:0] ID_CODE        = 32'h1a5c_e001, // arbitrary identification value
  parameter int          STARTUP_PHASES = tap_cfg_pkg::STARTUP_LEN,
  parameter int          DEPTH          = tap_cfg_pkg::FIFO_DEPTH
) (
  input  wire logic                          core_clk_in,
  input  wire logic                          sys_rst_in,
  input  wire logic                          tck_in,
  input  wire logic                          tms_in,
  input  wire logic                          tdi_in,
  input  wire logic                          program_n_in,
  input  wire logic                          config_clock_in,
  input  wire logic                          fabric_startup_clock_in,
  input  wire logic [1:0]                    startup_src_in,
  input  wire logic [tap_cfg_pkg::DR_W-1:0]  user_code_in,
  input  wire logic [tap_cfg_pkg::CFG_W-1:0] readback_word_in,
  input  wire logic [tap_cfg_pkg::CHAINS-1:0] fabric_tdo_in,
  input  wire logic                          cfg_ready_in,
  output logic                               tdo_out,
  output logic                               tdo_oe_out,
  output logic [tap_cfg_pkg::CFG_W-1:0]      cfg_word_out,
  output logic                               cfg_valid_out,
  output logic                               load_overrun_out,
  output logic                               configured_out,
  output logic [tap_cfg_pkg::CNT_W-1:0]      startup_phase_out,
  output logic                               seq_busy_out,
  output logic [tap_cfg_pkg::CHAINS-1:0]     fabric_sel_out,
  output logic                               fabric_tdi_out,
  output logic                               fabric_reset_out,
  output logic                               fabric_shift_out,
  output logic                               fabric_update_out,
  output logic                               fabric_capture_out
);
  import tap_cfg_pkg::*;

  localparam logic [CNT_W-1:0] LAST_PHASE = CNT_W'(STARTUP_PHASES - 1);
  localparam logic [CNT_W-1:0] TOP_PHASE  = CNT_W'(STARTUP_PHASES);

  initial
  begin
    if (ID_CODE[0] != 1'b1 || STARTUP_PHASES < 2 || STARTUP_PHASES > 15 || DEPTH < 2)
      $error("tap_cfg_port: unsupported parameter values");
  end

  // ---------------------------------------------------------------
  // pin synchronisers and edge detect
  // ---------------------------------------------------------------
  logic [5:0] pin_s1;
  logic [5:0] pin_s2;
  logic [5:0] pin_prev;

  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      pin_s1   <= 6'h08;
      pin_s2   <= 6'h08;
      pin_prev <= 6'h08;
    end
    else
    begin
      pin_s1   <= {fabric_startup_clock_in, config_clock_in, program_n_in, tdi_in, tms_in, tck_in};
      pin_s2   <= pin_s1;
      pin_prev <= pin_s2;
    end
  end

  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic tdi;
  logic program_low;
  logic config_clock_rise;
  logic fclk_rise;

  assign tck_rise    = pin_s2[0] && !pin_prev[0];
  assign tck_fall    = !pin_s2[0] && pin_prev[0];
  assign tms         = pin_s2[1];
  assign tdi         = pin_s2[2];
  assign program_low = !pin_s2[3];
  assign config_clock_rise   = pin_s2[4] && !pin_prev[4];
  assign fclk_rise   = pin_s2[5] && !pin_prev[5];

  // ---------------------------------------------------------------
  // tap state transitions
  // ---------------------------------------------------------------
  function automatic tap_state_t tap_next(input tap_state_t s, input logic m);
    unique case (s)
      TLR:      tap_next = m ? TLR    : RTI;
      RTI:      tap_next = m ? SEL_DR : RTI;
      SEL_DR:   tap_next = m ? SEL_IR : CAP_DR;
      CAP_DR:   tap_next = m ? EX1_DR : SHIFT_DR;
      SHIFT_DR: tap_next = m ? EX1_DR : SHIFT_DR;
      EX1_DR:   tap_next = m ? UPD_DR : PAUSE_DR;
      PAUSE_DR: tap_next = m ? EX2_DR : PAUSE_DR;
      EX2_DR:   tap_next = m ? UPD_DR : SHIFT_DR;
      UPD_DR:   tap_next = m ? SEL_DR : RTI;
      SEL_IR:   tap_next = m ? TLR    : CAP_IR;
      CAP_IR:   tap_next = m ? EX1_IR : SHIFT_IR;
      SHIFT_IR: tap_next = m ? EX1_IR : SHIFT_IR;
      EX1_IR:   tap_next = m ? UPD_IR : PAUSE_IR;
      PAUSE_IR: tap_next = m ? EX2_IR : PAUSE_IR;
      EX2_IR:   tap_next = m ? UPD_IR : SHIFT_IR;
      UPD_IR:   tap_next = m ? SEL_DR : RTI;
    endcase
  endfunction : tap_next

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  tap_state_t        tap_state, next_tap_state;
  seq_mode_t         seq_mode, next_seq_mode;
  logic [IR_W-1:0]   ir, next_ir;
  logic [IR_W-1:0]   ir_sr, next_ir_sr;
  logic [DR_W-1:0]   dr_sr, next_dr_sr;
  logic [CNT_W-1:0]  cfg_cnt, next_cfg_cnt;
  logic [CFG_W-1:0]  cfg_word, next_cfg_word;
  logic              word_pending, next_word_pending;
  logic              isc_enabled, next_isc_enabled;
  logic [CNT_W-1:0]  next_phase;
  logic              next_configured, next_overrun;
  logic              next_tdo, next_tdo_oe;
  logic [CHAINS-1:0] next_fabric_sel;
  logic [CHAINS-1:0] chain_hit;
  logic [CFG_W-1:0]  next_cfg_word_out;
  logic              next_cfg_valid_out;
  logic              seq_tick;
  logic              load_ok;
  logic              fifo_in_ready;
  logic [CFG_W-1:0]  fifo_data;
  logic              fifo_valid;
  logic              fifo_pop_ready;

  // per-chain instruction decode
  for (genvar g = 0; g < CHAINS; g++)
  begin : g_chain
    assign chain_hit[g] = (ir == CHAIN_OPS[g*IR_W +: IR_W]);
  end

  assign fifo_pop_ready = !cfg_valid_out || cfg_ready_in;

  // ---------------------------------------------------------------
  // next values
  // ---------------------------------------------------------------
  always_comb
  begin
    next_tap_state     = tap_state;
    next_ir            = ir;
    next_ir_sr         = ir_sr;
    next_dr_sr         = dr_sr;
    next_cfg_cnt       = cfg_cnt;
    next_cfg_word      = cfg_word;
    next_word_pending  = word_pending && !fifo_in_ready;
    next_isc_enabled   = isc_enabled;
    next_seq_mode      = seq_mode;
    next_phase         = startup_phase_out;
    next_configured    = configured_out;
    next_overrun       = load_overrun_out && !program_low;
    next_tdo           = tdo_out;
    next_tdo_oe        = tdo_oe_out;
    load_ok            = !configured_out && seq_mode == SEQ_IDLE;
    unique case (startup_src_in)
      SRC_CONFIG_CLOCK: seq_tick = config_clock_rise;
      SRC_FABRIC_CLOCK: seq_tick = fclk_rise;
      default:          seq_tick = tck_rise && tap_state == RTI;
    endcase
    if (tck_rise)
    begin
      next_tap_state = tap_next(tap_state, tms);
      unique case (tap_state)
        TLR:      next_ir = OP_IDCODE;
        CAP_IR:   next_ir_sr = {configured_out, 1'b1, isc_enabled, configured_out, IR_CAPTURE_LOW};
        SHIFT_IR: next_ir_sr = {tdi, ir_sr[IR_W-1:1]};
        UPD_IR:
        begin
          next_ir = ir_sr;
          if ((ir_sr == OP_STARTUP_CLOCK || ir_sr == OP_INSYS_CONFIG_EXIT) && load_ok)
          begin
            next_seq_mode = SEQ_UP;
            next_phase    = '0;
          end
          if ((ir_sr == OP_INSYS_CONFIG_ENTER || ir_sr == OP_SHUTDOWN_CLOCK) && configured_out
              && seq_mode == SEQ_IDLE)
          begin
            next_seq_mode = SEQ_DOWN;
            next_phase    = TOP_PHASE;
          end
        end
        CAP_DR:
        begin
          next_cfg_cnt = '0;
          unique case (ir)
            OP_IDCODE:   next_dr_sr = ID_CODE;
            OP_USERCODE: next_dr_sr = configured_out ? user_code_in : USERCODE_BLANK;
            OP_READBACK: next_dr_sr = {16'h0000, readback_word_in};
            default:     next_dr_sr = '0;
          endcase
        end
        SHIFT_DR:
        begin
          unique case (ir)
            OP_IDCODE, OP_USERCODE: next_dr_sr = {tdi, dr_sr[DR_W-1:1]};
            OP_READBACK:            next_dr_sr = {16'h0000, tdi, dr_sr[CFG_W-1:1]};
            OP_CONFIG_LOAD:
            begin
              next_dr_sr   = {16'h0000, dr_sr[CFG_W-2:0], tdi};
              next_cfg_cnt = cfg_cnt + 1'b1;
              if (cfg_cnt == 4'hf && load_ok)
              begin
                next_cfg_word     = {dr_sr[CFG_W-2:0], tdi};
                next_word_pending = 1'b1;
                if (word_pending && !fifo_in_ready)
                  next_overrun = 1'b1;
              end
            end
            default:                next_dr_sr = {31'h0, tdi};
          endcase
        end
        default: ;
      endcase
    end
    if (tck_fall)
    begin
      next_tdo_oe = (tap_state == SHIFT_IR || tap_state == SHIFT_DR);
      if (tap_state == SHIFT_IR)
        next_tdo = ir_sr[0];
      else if (|(chain_hit & fabric_sel_out))
        next_tdo = |(chain_hit & fabric_tdo_in);
      else if (ir == OP_CONFIG_LOAD)
        next_tdo = dr_sr[CFG_W-1];
      else
        next_tdo = dr_sr[0];
    end
    unique case (seq_mode)
      SEQ_IDLE: ;
      SEQ_UP:
        if (seq_tick && (startup_src_in != SRC_TAP_CLOCK || ir == OP_STARTUP_CLOCK || ir == OP_INSYS_CONFIG_EXIT))
        begin
          next_phase = startup_phase_out + 1'b1;
          if (startup_phase_out == LAST_PHASE)
          begin
            next_seq_mode    = SEQ_IDLE;
            next_configured  = 1'b1;
            next_isc_enabled = 1'b0;
          end
        end
      SEQ_DOWN:
        if (seq_tick && (startup_src_in != SRC_TAP_CLOCK || ir == OP_INSYS_CONFIG_ENTER || ir == OP_SHUTDOWN_CLOCK))
        begin
          next_phase = startup_phase_out - 1'b1;
          if (startup_phase_out == 4'h1)
          begin
            next_seq_mode    = SEQ_IDLE;
            next_configured  = 1'b0;
            next_isc_enabled = 1'b1;
          end
        end
      default: next_seq_mode = SEQ_IDLE;
    endcase
    if (program_low)
    begin
      next_configured = 1'b0;
      next_seq_mode   = SEQ_IDLE;
      next_phase      = '0;
    end
    next_fabric_sel    = next_configured ? chain_hit : '0;
    next_cfg_valid_out = fifo_pop_ready ? fifo_valid : cfg_valid_out;
    next_cfg_word_out  = (fifo_pop_ready && fifo_valid) ? fifo_data : cfg_word_out;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      tap_state          <= TLR;
      seq_mode           <= SEQ_IDLE;
      ir                 <= OP_IDCODE;
      ir_sr              <= '0;
      dr_sr              <= '0;
      cfg_cnt            <= '0;
      cfg_word           <= '0;
      word_pending       <= 1'b0;
      isc_enabled        <= 1'b0;
      startup_phase_out  <= '0;
      configured_out     <= 1'b0;
      load_overrun_out   <= 1'b0;
      tdo_out            <= 1'b0;
      tdo_oe_out         <= 1'b0;
      fabric_sel_out     <= '0;
      fabric_tdi_out     <= 1'b0;
      fabric_reset_out   <= 1'b1;
      fabric_shift_out   <= 1'b0;
      fabric_update_out  <= 1'b0;
      fabric_capture_out <= 1'b0;
      seq_busy_out       <= 1'b0;
      cfg_word_out       <= '0;
      cfg_valid_out      <= 1'b0;
    end
    else
    begin
      tap_state          <= next_tap_state;
      seq_mode           <= next_seq_mode;
      ir                 <= next_ir;
      ir_sr              <= next_ir_sr;
      dr_sr              <= next_dr_sr;
      cfg_cnt            <= next_cfg_cnt;
      cfg_word           <= next_cfg_word;
      word_pending       <= next_word_pending;
      isc_enabled        <= next_isc_enabled;
      startup_phase_out  <= next_phase;
      configured_out     <= next_configured;
      load_overrun_out   <= next_overrun;
      tdo_out            <= next_tdo;
      tdo_oe_out         <= next_tdo_oe;
      fabric_sel_out     <= next_fabric_sel;
      fabric_tdi_out     <= tdi;
      fabric_reset_out   <= (next_tap_state == TLR);
      fabric_shift_out   <= (next_tap_state == SHIFT_DR);
      fabric_update_out  <= (next_tap_state == UPD_DR);
      fabric_capture_out <= (next_tap_state == CAP_DR);
      seq_busy_out       <= (next_seq_mode != SEQ_IDLE);
      cfg_word_out       <= next_cfg_word_out;
      cfg_valid_out      <= next_cfg_valid_out;
    end
  end

  cfg_word_fifo #(
    .WIDTH (CFG_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .core_clk_in   (core_clk_in),
    .sys_rst_in    (sys_rst_in),
    .in_data_in    (cfg_word),
    .in_valid_in   (word_pending),
    .in_ready_out  (fifo_in_ready),
    .out_data_out  (fifo_data),
    .out_valid_out (fifo_valid),
    .out_ready_in  (fifo_pop_ready)
  );

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  bypass_clear_a: assert property (tck_rise && tap_state == CAP_DR && ir == OP_BYPASS |=> dr_sr[0] == 1'b0)
    else $error("bypass not cleared on capture");
  idcode_load_a: assert property (tck_rise && tap_state == CAP_DR && ir == OP_IDCODE |=> dr_sr == ID_CODE)
    else $error("identification value not captured");
  idcode_lsb_a: assert property (tck_rise && tap_state == CAP_DR && ir == OP_IDCODE |=> dr_sr[0])
    else $error("identification value does not end in one");
  cfg_word_a: assert property (tck_rise && tap_state == SHIFT_DR && ir == OP_CONFIG_LOAD && cfg_cnt == 4'hf
                               && load_ok && !program_low |=> word_pending ##0 cfg_word == {$past(dr_sr[14:0]), $past(tdi)})
    else $error("configuration word not assembled");
  usercode_blank_a: assert property (tck_rise && tap_state == CAP_DR && ir == OP_USERCODE && !configured_out
                                     |=> dr_sr == USERCODE_BLANK)
    else $error("blank usercode wrong");
  chain_gate_a: assert property (!configured_out |-> fabric_sel_out == '0)
    else $error("fabric chain selected while unconfigured");
  fabric_shift_a: assert property (tap_state == SHIFT_DR |-> fabric_shift_out)
    else $error("fabric shift indication wrong");
  reload_gate_a: assert property (configured_out && seq_mode == SEQ_IDLE |=> !$rose(word_pending))
    else $error("bitstream word taken while configured");
  tdo_fall_a: assert property ($changed(tdo_out) |-> $past(tck_fall))
    else $error("tdo changed away from a falling edge");
  startup_done_a: assert property (seq_mode == SEQ_UP && next_phase == TOP_PHASE && !program_low
                                   |=> configured_out && seq_mode == SEQ_IDLE)
    else $error("startup did not complete");
  shutdown_rev_a: assert property (seq_mode == SEQ_DOWN && $past(seq_mode) == SEQ_DOWN && !$past(program_low)
                                   && startup_phase_out != $past(startup_phase_out)
                                   |-> startup_phase_out == $past(startup_phase_out) - 1'b1)
    else $error("shutdown phase not descending");

endmodule : tap_cfg_port

// ### common/tap_cfg_pkg.sv
// Purpose: shared constants and types of the boundary-scan configuration port
// Assumes: 6-bit instruction register, 16-bit configuration words
// Notes:   opcodes and field layouts live here only

package tap_cfg_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int IR_W      = 6;
  localparam int DR_W      = 32;
  localparam int CFG_W     = 16;
  localparam int CNT_W     = 4;
  localparam int CHAINS    = 4;
  localparam int FIFO_DEPTH = 8;

  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [IR_W-1:0] OP_FABRIC_CHAIN_ONE   = 6'h02;
  localparam logic [IR_W-1:0] OP_FABRIC_CHAIN_TWO   = 6'h03;
  localparam logic [IR_W-1:0] OP_FABRIC_CHAIN_THREE = 6'h1a;
  localparam logic [IR_W-1:0] OP_FABRIC_CHAIN_FOUR  = 6'h1b;
  localparam logic [IR_W-1:0] OP_READBACK           = 6'h04;
  localparam logic [IR_W-1:0] OP_CONFIG_LOAD        = 6'h05;
  localparam logic [IR_W-1:0] OP_USERCODE           = 6'h08;
  localparam logic [IR_W-1:0] OP_IDCODE             = 6'h09;
  localparam logic [IR_W-1:0] OP_STARTUP_CLOCK      = 6'h0c;
  localparam logic [IR_W-1:0] OP_SHUTDOWN_CLOCK     = 6'h0d;
  localparam logic [IR_W-1:0] OP_INSYS_CONFIG_ENTER = 6'h10;
  localparam logic [IR_W-1:0] OP_INSYS_CONFIG_EXIT  = 6'h16;
  localparam logic [IR_W-1:0] OP_BYPASS             = 6'h3f;

  localparam logic [CHAINS*IR_W-1:0] CHAIN_OPS =
    {OP_FABRIC_CHAIN_FOUR, OP_FABRIC_CHAIN_THREE, OP_FABRIC_CHAIN_TWO, OP_FABRIC_CHAIN_ONE};

  // ---------------------------------------------------------------
  // fixed values
  // ---------------------------------------------------------------
  localparam logic [1:0]      IR_CAPTURE_LOW = 2'h1;
  localparam logic [DR_W-1:0] USERCODE_BLANK = 32'h0fffffff;
  localparam int              STARTUP_LEN    = 8;

  // startup clock source option
  localparam logic [1:0] SRC_CONFIG_CLOCK = 2'h0;
  localparam logic [1:0] SRC_FABRIC_CLOCK = 2'h1;
  localparam logic [1:0] SRC_TAP_CLOCK    = 2'h2;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    TLR      = 4'h0, RTI      = 4'h1, SEL_DR   = 4'h3, CAP_DR   = 4'h2,
    SHIFT_DR = 4'h6, EX1_DR   = 4'h7, PAUSE_DR = 4'h5, EX2_DR   = 4'h4,
    UPD_DR   = 4'hc, SEL_IR   = 4'hd, CAP_IR   = 4'hf, SHIFT_IR = 4'he,
    EX1_IR   = 4'ha, PAUSE_IR = 4'hb, EX2_IR   = 4'h9, UPD_IR   = 4'h8
  } tap_state_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_UP   = 2'h1,
    SEQ_DOWN = 2'h3
  } seq_mode_t;

endpackage : tap_cfg_pkg

// ### rtl/cfg_word_fifo.sv
// Purpose: small first-in first-out buffer for configuration words
// Assumes: single clock, synchronous active-high reset
// Notes:   depth must be a power of two

module cfg_word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  output logic [WIDTH-1:0]      out_data_out,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in
);

  localparam int AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
      $error("cfg_word_fifo: depth must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic [AW:0]      next_wr_ptr;
  logic [AW:0]      next_rd_ptr;
  logic             push;
  logic             pop;

  // ---------------------------------------------------------------
  // pointers and flags
  // ---------------------------------------------------------------
  always_comb
  begin
    in_ready_out  = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
    out_valid_out = (wr_ptr != rd_ptr);
    push          = in_valid_in && in_ready_out;
    pop           = out_valid_out && out_ready_in;
    next_wr_ptr   = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr   = pop ? rd_ptr + 1'b1 : rd_ptr;
    out_data_out  = mem[rd_ptr[AW-1:0]];
  end

  always_ff @(posedge core_clk_in)
  begin
    if (sys_rst_in)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (push)
      mem[wr_ptr[AW-1:0]] <= in_data_in;
  end

endmodule : cfg_word_fifo

// ### dv/tap_host_model.sv
// Purpose: tap controller model driving tck, tms and tdi
// Assumes: tck stands low between scans
// Notes:   period alternates 12 and 13 core cycles
module tap_host_model (
  input  wire logic core_clk_in,
  input  wire logic tdo_in,
  output logic      tck_out,
  output logic      tms_out,
  output logic      tdi_out
);
  timeunit 1ns;
  timeprecision 100ps;
  bit ph;
  initial
  begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b0;
  end
  task automatic clk1(input logic ms, input logic di, output logic b);
    tms_out = ms;
    tdi_out = di;
    ph = !ph;
    repeat (6 + ph) @(negedge core_clk_in);
    b = tdo_in;
    tck_out = 1'b1;
    repeat (6) @(negedge core_clk_in);
    tck_out = 1'b0;
  endtask : clk1
  task automatic walk(input logic [15:0] pat, input int n);
    logic b;
    for (int i = 0; i < n; i++)
      clk1(pat[i], 1'b0, b);
  endtask : walk
  task automatic shift(input logic [31:0] v, input int n, input bit msb, output logic [31:0] r);
    logic b;
    r = '0;
    for (int i = 0; i < n; i++)
    begin
      clk1(i == n - 1, msb ? v[n - 1 - i] : v[i], b);
      r[i] = b;
    end
  endtask : shift
  task automatic ir(input logic [5:0] op);
    logic [31:0] r;
    walk(16'h0003, 4);
    shift({26'h0, op}, 6, 1'b0, r);
    walk(16'h0001, 2);
  endtask : ir
  task automatic dr(input logic [31:0] v, input int n, input bit msb, output logic [31:0] r);
    walk(16'h0001, 3);
    shift(v, n, msb, r);
    walk(16'h0001, 2);
  endtask : dr
endmodule : tap_host_model

// ### dv/tb_top.sv
// Purpose: self-checking bench of the configuration port
// Assumes: eight startup phases, tap or config clock
// Notes:   config words stalled in the fifo
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import tap_cfg_pkg::*;
  localparam logic [31:0] ID = 32'h2b6d_4e01; // arbitrary identification value
  localparam logic [31:0] UC = 32'h1234_5678;
  logic        clk, rst, rdy, tck, tms, tdi, tdo, valid, conf, prog, config_clock, busy, oe, ovr;
  logic [1:0]  src;
  logic [3:0]  phase, fab, fsel;
  logic [15:0] word;
  logic [31:0] r;
  int          n_mismatch, check_count;
  int          cyc = 0;
  always #5 clk = !clk;
  always #10 config_clock = !config_clock;
  tap_cfg_port #(.ID_CODE(ID)) tap_cfg_port_i (
    .core_clk_in(clk), .sys_rst_in(rst), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
    .program_n_in(prog), .config_clock_in(config_clock), .fabric_startup_clock_in(1'b0),
    .startup_src_in(src), .user_code_in(UC), .readback_word_in(16'h0),
    .fabric_tdo_in(4'h1), .cfg_ready_in(rdy), .tdo_out(tdo), .tdo_oe_out(oe),
    .cfg_word_out(word), .cfg_valid_out(valid), .load_overrun_out(ovr), .configured_out(conf),
    .startup_phase_out(phase), .seq_busy_out(busy), .fabric_sel_out(fsel), .fabric_tdi_out(),
    .fabric_reset_out(fab[3]), .fabric_shift_out(fab[2]), .fabric_update_out(fab[1]), .fabric_capture_out(fab[0]));
  tap_host_model tap_host_model_i (.core_clk_in(clk), .tdo_in(tdo), .tck_out(tck), .tms_out(tms), .tdi_out(tdi));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  task automatic t_ident;
    tap_host_model_i.dr(32'h0, 32, 1'b0, r);
    chk(r, ID);
    chk(r & 32'h1, 32'h1);
    tap_host_model_i.ir(OP_USERCODE);
    tap_host_model_i.dr(32'h0, 32, 1'b0, r);
    chk(r, USERCODE_BLANK);
  endtask : t_ident
  task automatic t_bypass;
    tap_host_model_i.ir(OP_BYPASS);
    tap_host_model_i.dr(32'ha5, 8, 1'b0, r);
    chk(r & 32'hff, 32'h4a);
    tap_host_model_i.ir(OP_FABRIC_CHAIN_ONE);
    tap_host_model_i.dr(32'ha5, 8, 1'b0, r);
    chk({fsel, r[7:0]}, 12'h04a);
  endtask : t_bypass
  task automatic t_load;
    tap_host_model_i.ir(OP_CONFIG_LOAD);
    tap_host_model_i.dr(32'hc3a1_5e07, 32, 1'b1, r);
    chk({valid, word}, 17'h1c3a1);
    rdy = 1'b1;
    @(negedge clk);
    chk({valid, word}, 17'h15e07);
    @(negedge clk);
    rdy = 1'b0;
    chk({ovr, valid}, 2'h0);
  endtask : t_load
  task automatic t_start;
    tap_host_model_i.ir(OP_STARTUP_CLOCK);
    tap_host_model_i.walk(16'h0, 7);
    chk({conf, busy, phase}, 6'h17);
    tap_host_model_i.walk(16'h0, 9);
    chk({conf, busy}, 2'h2);
    tap_host_model_i.walk(16'h0007, 4);
    tap_host_model_i.ir(OP_USERCODE);
    tap_host_model_i.dr(32'h0, 32, 1'b0, r);
    chk(r, UC);
    tap_host_model_i.ir(OP_FABRIC_CHAIN_ONE);
    tap_host_model_i.dr(32'h0, 8, 1'b0, r);
    chk({fsel, r[7:0]}, 12'h1ff);
  endtask : t_start
  task automatic t_refuse;
    tap_host_model_i.ir(OP_CONFIG_LOAD);
    tap_host_model_i.dr(32'hffff, 16, 1'b1, r);
    chk(valid, 1'b0);
  endtask : t_refuse
  task automatic t_down;
    tap_host_model_i.ir(OP_INSYS_CONFIG_ENTER);
    tap_host_model_i.walk(16'h0, 4);
    chk({conf, busy, phase}, 6'h34);
    tap_host_model_i.walk(16'h0, 4);
    chk({conf, busy}, 2'h0);
  endtask : t_down
  task automatic t_reload;
    tap_host_model_i.ir(OP_CONFIG_LOAD);
    tap_host_model_i.dr(32'h6c1f, 16, 1'b1, r);
    chk({valid, word}, 17'h16c1f);
    rdy = 1'b1;
    @(negedge clk);
    rdy = 1'b0;
    src = SRC_CONFIG_CLOCK;
    tap_host_model_i.ir(OP_INSYS_CONFIG_EXIT);
    repeat (20) @(negedge clk);
    chk({conf, busy}, 2'h2);
    prog = 1'b0;
    repeat (4) @(negedge clk);
    chk({conf, phase}, 5'h00);
    prog = 1'b1;
    tap_host_model_i.ir(OP_CONFIG_LOAD);
    tap_host_model_i.dr(32'h5a3c, 16, 1'b1, r);
    chk({valid, word}, 17'h15a3c);
  endtask : t_reload
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      end_sim();
    end
  end
  initial
  begin
    clk = 1'b0;
    config_clock = 1'b0;
    prog = 1'b1;
    src = SRC_TAP_CLOCK;
    rst = 1'b1;
    rdy = 1'b0;
    n_mismatch = 0;
    check_count = 0;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    chk({oe, fab}, 5'h08);
    tap_host_model_i.walk(16'h001f, 6);
    chk({oe, fab}, 5'h00);
    t_ident();
    t_bypass();
    t_load();
    t_start();
    t_refuse();
    t_down();
    t_reload();
    end_sim();
  end
endmodule : tb_top
